// >>> power_good_out_pkg.sv
// shared constants and types for the power-good and sleep control block
// assumes a single 10 MHz clock and synchronous active-high reset
package power_good_out_pkg;
	localparam int NUM_INT_REG = 4;
	localparam int SYNC_STAGES = 2;
	localparam int CLK_PERIOD_NS = 100;
	// settle time after all power-ok before reset release
	localparam int RESET_HOLD_NS = 1000;
	localparam int RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] RESET_HOLD_CNT = 4'(RESET_HOLD_CYC);
	localparam logic [3:0] HOLD_CNT_RST = 4'h0;
	localparam logic SLEEP_ROLE_LEADER = 1'b0;
	localparam logic SLEEP_ROLE_FOLLOWER = 1'b1;
	localparam logic LSW_SEL_LOAD_SWITCH = 1'b1;

	typedef enum logic [1:0] {
		ST_ACTIVE = 2'b00,
		ST_REQUEST = 2'b01,
		ST_DEEP_SLEEP = 2'b10
	} sleep_state_t;
endpackage : power_good_out_pkg

// >>> sync_if.sv
// carries synchronised pin levels from the input stage to the control logic
// assumes both ends share CLK
`timescale 1ns/1ps
interface sync_if;
	logic sleep_acknowledge_in;
	logic sleep_mode_in;
	logic ext_regulator_power_ok_in;
	logic load_switch_three_feedback;
	modport source (output sleep_acknowledge_in, sleep_mode_in, ext_regulator_power_ok_in,
		load_switch_three_feedback);
	modport sink (input sleep_acknowledge_in, sleep_mode_in, ext_regulator_power_ok_in,
		load_switch_three_feedback);
endinterface : sync_if

// >>> pin_sync.sv
// two-stage synchronisers for the asynchronous control pins
// assumes pins are asynchronous to CLK
`timescale 1ns/1ps
module pin_sync (
	input wire logic clk,
	input wire logic reset,
	input wire logic [3:0] pins,
	sync_if.source sync
);
	import power_good_out_pkg::*;
	logic [3:0] stage1;
	logic [3:0] stage2;
	logic [3:0] next_stage1;
	logic [3:0] next_stage2;

	always_comb begin
		next_stage1 = pins;
		next_stage2 = stage1;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			stage1 <= 4'h0;
			stage2 <= 4'h0;
		end else begin
			stage1 <= next_stage1;
			stage2 <= next_stage2;
		end
	end

	assign sync.sleep_acknowledge_in = stage2[0];
	assign sync.sleep_mode_in = stage2[1];
	assign sync.ext_regulator_power_ok_in = stage2[2];
	assign sync.load_switch_three_feedback = stage2[3];
endmodule : pin_sync

// >>> pwr_ok_combiner.sv
// combines every power-ok source and brownout into one good level
// assumes all inputs already synchronised or on CLK
`timescale 1ns/1ps
module pwr_ok_combiner (
	input wire logic [power_good_out_pkg::NUM_INT_REG-1:0] reg_ok,
	input wire logic [power_good_out_pkg::NUM_INT_REG-1:0] reg_en,
	input wire logic ext_en,
	input wire logic brownout,
	sync_if.sink sync,
	output logic all_ok
);
	import power_good_out_pkg::*;
	logic [NUM_INT_REG-1:0] reg_good;

	// disabled regulators do not block power-good
	genvar i;
	generate
		for (i = 0; i < NUM_INT_REG; i++) begin : g_reg
			assign reg_good[i] = reg_ok[i] | ~reg_en[i];
		end
	endgenerate

	always_comb begin
		all_ok = &reg_good;
		if (ext_en && !sync.ext_regulator_power_ok_in) begin
			all_ok = 1'b0;
		end
		if (brownout) begin
			all_ok = 1'b0;
		end
	end
endmodule : pwr_ok_combiner

// >>> pmic_sleep_and_power_good_ctrl.sv
// top-level control pins: power-good, reset, write-protect, sleep handshake,
// external regulator enables and inrush / load-switch-3 pin sharing
// assumes OTP settings and regulator status are on CLK; pins are asynchronous
`timescale 1ns/1ps

module pmic_sleep_and_power_good_ctrl (
	// clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// otp configuration
	input wire logic SLEEP_ROLE_SETTING,
	input wire logic OTP_LOAD_SWITCH_SELECT,
	// internal regulator status
	input wire logic [power_good_out_pkg::NUM_INT_REG-1:0] REGULATOR_POWER_OK,
	input wire logic [power_good_out_pkg::NUM_INT_REG-1:0] REGULATOR_ENABLED,
	input wire logic SYS_BROWNOUT,
	// sequencer requests
	input wire logic EXT_REG_1_ON,
	input wire logic EXT_REG_2_ON,
	input wire logic INRUSH_ON,
	input wire logic LOAD_SWITCH_THREE_ON,
	input wire logic WRITE_PROTECT_ON,
	// pins from the host and board
	input wire logic SLEEP_ACKNOWLEDGE_IN,
	input wire logic SLEEP_MODE_IN,
	input wire logic EXT_REGULATOR_POWER_OK_IN,
	input wire logic INRUSH_OUTPUT_SENSE,
	// open-drain pins: out is the driven level, oe_n low while driving
	output logic POWER_GOOD_OUT,
	output logic POWER_GOOD_OE_N,
	output logic RESET_N_OUT,
	output logic RESET_N_OE_N,
	output logic WRITE_PROTECT_N_OUT,
	output logic WRITE_PROTECT_N_OE_N,
	output logic SLEEP_REQUEST_OUT,
	output logic SLEEP_REQUEST_OE_N,
	output logic EXT_REGULATOR_ENABLE_1,
	output logic EXT_REGULATOR_ENABLE_1_OE_N,
	output logic EXT_REGULATOR_ENABLE_2,
	output logic EXT_REGULATOR_ENABLE_2_OE_N,
	// gate drive, inrush or load switch 3
	output logic INRUSH_GATE_DRIVE,
	// status toward the sequencer
	output logic DEEP_SLEEP_STATE,
	output logic LOAD_SWITCH_THREE_FEEDBACK
);
	import power_good_out_pkg::*;

	// ----------------------------------------
	// input synchronisation
	// ----------------------------------------
	sync_if sync ();
	logic all_ok;

	pin_sync u_sync (
		.clk(CLK),
		.reset(RESET),
		.pins({INRUSH_OUTPUT_SENSE, EXT_REGULATOR_POWER_OK_IN, SLEEP_MODE_IN,
			SLEEP_ACKNOWLEDGE_IN}),
		.sync(sync.source)
	);

	pwr_ok_combiner u_comb (
		.reg_ok(REGULATOR_POWER_OK),
		.reg_en(REGULATOR_ENABLED),
		.ext_en(EXT_REG_1_ON | EXT_REG_2_ON),
		.brownout(SYS_BROWNOUT),
		.sync(sync.sink),
		.all_ok(all_ok)
	);

	// ----------------------------------------
	// power-good and reset release
	// ----------------------------------------
	logic [3:0] hold_cnt;
	logic [3:0] next_hold_cnt;
	logic power_good_out;
	logic next_power_good_out;
	logic rst_rel;
	logic next_rst_rel;

	always_comb begin
		next_hold_cnt = hold_cnt;
		next_power_good_out = all_ok;
		next_rst_rel = rst_rel;
		if (!all_ok) begin
			next_hold_cnt = HOLD_CNT_RST;
		end else if (hold_cnt != RESET_HOLD_CNT) begin
			next_hold_cnt = hold_cnt + 4'h1;
		end else begin
			next_rst_rel = 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			hold_cnt <= HOLD_CNT_RST;
			power_good_out <= 1'b0;
			rst_rel <= 1'b0;
		end else begin
			hold_cnt <= next_hold_cnt;
			power_good_out <= next_power_good_out;
			rst_rel <= next_rst_rel;
		end
	end

	// ----------------------------------------
	// sleep handshake
	// ----------------------------------------
	sleep_state_t state;
	sleep_state_t next_state;
	logic ack_prev;
	logic ack_rise;

	assign ack_rise = sync.sleep_acknowledge_in & ~ack_prev;

	always_comb begin
		next_state = state;
		case (state)
			ST_ACTIVE: begin
				if (SLEEP_ROLE_SETTING == SLEEP_ROLE_FOLLOWER) begin
					if (ack_rise) begin
						next_state = ST_DEEP_SLEEP;
					end
				end else if (sync.sleep_mode_in) begin
					next_state = ST_REQUEST;
				end
			end
			ST_REQUEST: begin
				if (sync.sleep_acknowledge_in) begin
					next_state = ST_DEEP_SLEEP;
				end else if (!sync.sleep_mode_in) begin
					next_state = ST_ACTIVE;
				end
			end
			ST_DEEP_SLEEP: begin
				// wake when acknowledge drops (follower) or when mode and acknowledge are both low (leader)
				if (SLEEP_ROLE_SETTING == SLEEP_ROLE_FOLLOWER) begin
					if (!sync.sleep_acknowledge_in) begin
						next_state = ST_ACTIVE;
					end
				end else if (!sync.sleep_mode_in && !sync.sleep_acknowledge_in) begin
					next_state = ST_ACTIVE;
				end
			end
			default: begin
				next_state = ST_ACTIVE;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			state <= ST_ACTIVE;
			ack_prev <= 1'b0;
		end else begin
			state <= next_state;
			ack_prev <= sync.sleep_acknowledge_in;
		end
	end

	// ----------------------------------------
	// output registers
	// ----------------------------------------
	logic next_req;
	logic next_lsw;
	logic next_en1;
	logic next_en2;
	logic next_wp;
	logic next_gate;

	always_comb begin
		next_req = (SLEEP_ROLE_SETTING == SLEEP_ROLE_LEADER) && (next_state == ST_REQUEST);
		next_lsw = (OTP_LOAD_SWITCH_SELECT == LSW_SEL_LOAD_SWITCH);
		next_gate = next_lsw ? LOAD_SWITCH_THREE_ON : INRUSH_ON;
		next_en1 = EXT_REG_1_ON;
		next_en2 = EXT_REG_2_ON;
		next_wp = WRITE_PROTECT_ON;
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			POWER_GOOD_OUT <= 1'b0;
			POWER_GOOD_OE_N <= 1'b0;
			RESET_N_OUT <= 1'b0;
			RESET_N_OE_N <= 1'b0;
			WRITE_PROTECT_N_OUT <= 1'b0;
			WRITE_PROTECT_N_OE_N <= 1'b0;
			SLEEP_REQUEST_OUT <= 1'b0;
			SLEEP_REQUEST_OE_N <= 1'b0;
			EXT_REGULATOR_ENABLE_1 <= 1'b0;
			EXT_REGULATOR_ENABLE_1_OE_N <= 1'b0;
			EXT_REGULATOR_ENABLE_2 <= 1'b0;
			EXT_REGULATOR_ENABLE_2_OE_N <= 1'b0;
			INRUSH_GATE_DRIVE <= 1'b0;
			DEEP_SLEEP_STATE <= 1'b0;
			LOAD_SWITCH_THREE_FEEDBACK <= 1'b0;
		end else begin
			// open drain: drive low, release for high
			POWER_GOOD_OUT <= 1'b0;
			POWER_GOOD_OE_N <= next_power_good_out & rst_rel;
			RESET_N_OUT <= 1'b0;
			RESET_N_OE_N <= next_rst_rel;
			WRITE_PROTECT_N_OUT <= 1'b0;
			WRITE_PROTECT_N_OE_N <= ~next_wp;
			SLEEP_REQUEST_OUT <= 1'b0;
			SLEEP_REQUEST_OE_N <= next_req;
			EXT_REGULATOR_ENABLE_1 <= 1'b0;
			EXT_REGULATOR_ENABLE_1_OE_N <= next_en1;
			EXT_REGULATOR_ENABLE_2 <= 1'b0;
			EXT_REGULATOR_ENABLE_2_OE_N <= next_en2;
			INRUSH_GATE_DRIVE <= next_gate;
			DEEP_SLEEP_STATE <= (next_state == ST_DEEP_SLEEP);
			LOAD_SWITCH_THREE_FEEDBACK <= next_lsw & sync.load_switch_three_feedback;
		end
	end
endmodule : pmic_sleep_and_power_good_ctrl

// >>> power_good_out_host_model.sv
// host controller model for the low-power handshake
// assumes req_pin is the pulled-up request line; ack moves at falling edge
`timescale 1ns/1ps
module power_good_out_host_model (
	// clock
	input wire logic clk,
	// handshake
	input wire logic req_pin,
	input wire logic force_ack,
	input wire logic [3:0] delay,
	output logic ack
);
	logic [3:0] waited = 4'h0;
	initial ack = 1'h0;
	// ----
	// answer a held request after delay cycles; force_ack acts alone
	// ----
	always @(negedge clk) begin
		waited <= req_pin ? waited + 4'((waited != delay)) : 4'h0;
		ack <= force_ack | (req_pin && waited == delay);
	end
endmodule : power_good_out_host_model

// >>> power_good_out_ctrl_checker.sv
// pin-level assertions for the power-good and sleep block
// assumes a bind by name onto the top module
`timescale 1ns/1ps
module power_good_out_ctrl_checker (
	// clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// inputs
	input wire logic OTP_LOAD_SWITCH_SELECT,
	input wire logic [power_good_out_pkg::NUM_INT_REG-1:0] REGULATOR_POWER_OK,
	input wire logic [power_good_out_pkg::NUM_INT_REG-1:0] REGULATOR_ENABLED,
	input wire logic SYS_BROWNOUT,
	input wire logic EXT_REG_1_ON,
	input wire logic INRUSH_ON,
	input wire logic LOAD_SWITCH_THREE_ON,
	input wire logic SLEEP_ACKNOWLEDGE_IN,
	input wire logic SLEEP_MODE_IN,
	// outputs
	input wire logic POWER_GOOD_OE_N,
	input wire logic RESET_N_OE_N,
	input wire logic SLEEP_REQUEST_OE_N,
	input wire logic EXT_REGULATOR_ENABLE_1_OE_N,
	input wire logic INRUSH_GATE_DRIVE,
	input wire logic DEEP_SLEEP_STATE
);
	import power_good_out_pkg::*;
	wire logic ok_now = &(REGULATOR_POWER_OK | ~REGULATOR_ENABLED) && !SYS_BROWNOUT;
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	a_power_good_out_reg_loss: assert property (
		(|(REGULATOR_ENABLED & ~REGULATOR_POWER_OK)) |=> !POWER_GOOD_OE_N)
		else $error("power good held with a regulator down");
	a_power_good_out_brownout: assert property (
		SYS_BROWNOUT |=> !POWER_GOOD_OE_N) else $error("power good held in brownout");
	a_power_good_out_needs_reset: assert property (
		POWER_GOOD_OE_N |-> RESET_N_OE_N) else $error("power good before reset release");
	a_reset_settle: assert property (
		$rose(RESET_N_OE_N) |-> $past(ok_now) && $past(ok_now, 10))
		else $error("reset released without settle time");
	a_request_sync: assert property (
		$rose(SLEEP_REQUEST_OE_N) |-> $past(SLEEP_MODE_IN, 3))
		else $error("request without synchronised mode");
	a_sleep_sync: assert property (
		$rose(DEEP_SLEEP_STATE) |-> $past(SLEEP_ACKNOWLEDGE_IN, 3))
		else $error("deep sleep without synchronised ack");
	a_ext_enable: assert property (
		1 |=> EXT_REGULATOR_ENABLE_1_OE_N == $past(EXT_REG_1_ON)) else $error("enable 1 wrong");
	a_gate_select: assert property (
		1 |=> INRUSH_GATE_DRIVE == ($past(OTP_LOAD_SWITCH_SELECT) ?
		$past(LOAD_SWITCH_THREE_ON) : $past(INRUSH_ON))) else $error("gate drive wrong");
endmodule : power_good_out_ctrl_checker

// >>> tb_pmic_sleep_and_power_good_ctrl.sv
// self-checking bench for the power-good and sleep block
// assumes released open-drain pins read high through pull-ups
`timescale 1ns/1ps
module tb_pmic_sleep_and_power_good_ctrl;
	import power_good_out_pkg::*;
	logic CLK = 0, RESET = 1, SLEEP_ROLE_SETTING = 0, OTP_LOAD_SWITCH_SELECT = 0;
	logic [NUM_INT_REG-1:0] REGULATOR_POWER_OK = '1, REGULATOR_ENABLED = '1;
	logic SYS_BROWNOUT = 0, EXT_REG_1_ON = 0, EXT_REG_2_ON = 0, INRUSH_ON = 0;
	logic LOAD_SWITCH_THREE_ON = 0, WRITE_PROTECT_ON = 0, SLEEP_MODE_IN = 0;
	logic EXT_REGULATOR_POWER_OK_IN = 1, INRUSH_OUTPUT_SENSE = 0, force_ack = 0;
	logic SLEEP_ACKNOWLEDGE_IN, POWER_GOOD_OUT, POWER_GOOD_OE_N, RESET_N_OUT, RESET_N_OE_N;
	logic WRITE_PROTECT_N_OUT, WRITE_PROTECT_N_OE_N, SLEEP_REQUEST_OUT, SLEEP_REQUEST_OE_N;
	logic EXT_REGULATOR_ENABLE_1, EXT_REGULATOR_ENABLE_1_OE_N, EXT_REGULATOR_ENABLE_2;
	logic EXT_REGULATOR_ENABLE_2_OE_N, INRUSH_GATE_DRIVE, DEEP_SLEEP_STATE;
	logic LOAD_SWITCH_THREE_FEEDBACK;
	logic [3:0] dly = 4'h1;
	int n_errors = 0, cmp_count = 0, k;
	always #50 CLK = ~CLK;
	pmic_sleep_and_power_good_ctrl i_pmic_sleep_and_power_good_ctrl (.*);
	power_good_out_host_model i_power_good_out_host_model (.clk(CLK), .req_pin(SLEEP_REQUEST_OE_N),
		.force_ack(force_ack), .delay(dly), .ack(SLEEP_ACKNOWLEDGE_IN));
	// ----
	// helpers
	// ----
	task tick(input int n);
		repeat (n) @(negedge CLK);
	endtask : tick
	task chk(input string n, input logic e, input logic g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s expected %b seen %b", n, e, g);
		end
	endtask : chk
	task complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : complete_run
	task bound(input logic ok);
		chk("wait", 1'h1, ok);
		if (ok !== 1'h1) complete_run();
	endtask : bound
	// ----
	// scenarios
	// ----
	task t_power_up;
		RESET = 0;
		tick(9);
		chk("reset_n", 1'h0, RESET_N_OE_N);
		for (k = 0; k < 8 && RESET_N_OE_N !== 1'h1; k++) tick(1);
		bound(RESET_N_OE_N);
		// power-good follows the registered release one cycle later
		tick(1);
		chk("power_good_out", 1'h1, POWER_GOOD_OE_N);
	endtask : t_power_up
	task t_power_good_out;
		for (k = 0; k < NUM_INT_REG; k++) begin
			REGULATOR_POWER_OK[k] = 0;
			tick(1);
			chk("power_good_out_loss", 1'h0, POWER_GOOD_OE_N);
			REGULATOR_ENABLED[k] = 0;
			tick(1);
			chk("power_good_out_off", 1'h1, POWER_GOOD_OE_N);
			REGULATOR_POWER_OK[k] = 1;
			REGULATOR_ENABLED[k] = 1;
		end
		SYS_BROWNOUT = 1;
		tick(1);
		chk("power_good_out_bo", 1'h0, POWER_GOOD_OE_N);
		chk("reset_kept", 1'h1, RESET_N_OE_N);
		SYS_BROWNOUT = 0;
		EXT_REG_1_ON = 1;
		EXT_REGULATOR_POWER_OK_IN = 0;
		tick(4);
		chk("power_good_out_ext", 1'h0, POWER_GOOD_OE_N);
		chk("ext_en1", 1'h1, EXT_REGULATOR_ENABLE_1_OE_N);
		EXT_REGULATOR_POWER_OK_IN = 1;
		tick(4);
		chk("power_good_out_back", 1'h1, POWER_GOOD_OE_N);
	endtask : t_power_good_out
	task t_pins;
		INRUSH_OUTPUT_SENSE = 1;
		for (k = 0; k < 4; k++) begin
			{OTP_LOAD_SWITCH_SELECT, LOAD_SWITCH_THREE_ON} = 2'(k);
			INRUSH_ON = !k[0];
			EXT_REG_2_ON = k[0];
			WRITE_PROTECT_ON = k[1];
			tick(4);
			chk("gate", k[1] ? k[0] : !k[0], INRUSH_GATE_DRIVE);
			chk("feedback", k[1], LOAD_SWITCH_THREE_FEEDBACK);
			chk("ext_en2", k[0], EXT_REGULATOR_ENABLE_2_OE_N);
			chk("wp", !k[1], WRITE_PROTECT_N_OE_N);
			chk("od_low", 1'h0, POWER_GOOD_OUT | RESET_N_OUT | WRITE_PROTECT_N_OUT |
				SLEEP_REQUEST_OUT | EXT_REGULATOR_ENABLE_1 | EXT_REGULATOR_ENABLE_2);
		end
	endtask : t_pins
	task t_leader;
		force_ack = 1;
		tick(6);
		chk("no_req_sleep", 1'h0, DEEP_SLEEP_STATE);
		force_ack = 0;
		dly = 4'h6;
		// let the synchronised acknowledge fall before the mode pin rises
		tick(4);
		SLEEP_MODE_IN = 1;
		tick(4);
		chk("request", 1'h1, SLEEP_REQUEST_OE_N);
		for (k = 0; k < 20 && DEEP_SLEEP_STATE !== 1'h1; k++) tick(1);
		bound(DEEP_SLEEP_STATE);
		chk("req_drop", 1'h0, SLEEP_REQUEST_OE_N);
		SLEEP_MODE_IN = 0;
		for (k = 0; k < 20 && DEEP_SLEEP_STATE !== 1'h0; k++) tick(1);
		bound(!DEEP_SLEEP_STATE);
	endtask : t_leader
	task t_follower;
		RESET = 1;
		SLEEP_ROLE_SETTING = 1;
		SLEEP_MODE_IN = 0;
		tick(2);
		RESET = 0;
		force_ack = 1;
		for (k = 0; k < 20 && DEEP_SLEEP_STATE !== 1'h1; k++) tick(1);
		bound(DEEP_SLEEP_STATE);
		chk("follower_req", 1'h0, SLEEP_REQUEST_OE_N);
		force_ack = 0;
		for (k = 0; k < 20 && DEEP_SLEEP_STATE !== 1'h0; k++) tick(1);
		bound(!DEEP_SLEEP_STATE);
	endtask : t_follower
	initial begin
		tick(16);
		t_power_up();
		t_power_good_out();
		t_pins();
		t_leader();
		t_follower();
		complete_run();
	end
endmodule : tb_pmic_sleep_and_power_good_ctrl
bind pmic_sleep_and_power_good_ctrl power_good_out_ctrl_checker i_power_good_out_ctrl_checker (.*);
